// ==== rtl/psr_frame_dec.sv ====
/*
 Frame decoder: accepts a received CAN frame, checks identifier and
 length, and forwards a read or write request for one clock.
 Assumes frames arrive as one-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_frame_dec
   import psr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [28:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   input wire logic [7:0] unit_addr,
   psr_frame_if.dec fr
);
   logic id_ok;
   assign id_ok = rx_id == (ID_REQ_BASE | {21'h0, unit_addr});

   // Command and parameter each arrive low byte first
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fr.req <= 1'b0;
         fr.wr <= 1'b0;
         fr.cmd <= 16'h0000;
         fr.data <= 16'h0000;
      end else begin
         fr.req <= rx_valid && id_ok && (rx_dlc == DLC_READ || rx_dlc == DLC_WRITE); // [R18] [R19]
         fr.wr <= rx_dlc == DLC_WRITE; // [R18]
         fr.cmd <= {rx_data[15:8], rx_data[7:0]};
         fr.data <= {rx_data[31:24], rx_data[23:16]};
      end
   end

   req_one_cycle_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fr.req |=> !fr.req || $past(rx_valid)) else $error("request without frame");
endmodule
`default_nettype wire

// ==== rtl/psr_frame_if.sv ====
/*
 Carrier for one parsed request between the frame decoder and the
 register core. Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface psr_frame_if;
   logic req;
   logic wr;
   logic [15:0] cmd;
   logic [15:0] data;
   modport dec (output req, output wr, output cmd, output data);
   modport core (input req, input wr, input cmd, input data);
endinterface
`default_nettype wire

// ==== rtl/psr_pkg.sv ====
/*
 Constants for the supply status and configuration register set:
 command codes, field positions, reset values and timing counts.
 Assumes a 10 MHz core clock.
*/
package psr_pkg;
   localparam logic [15:0] CMD_OPERATION = 16'h0000;
   localparam logic [15:0] CMD_VOLTAGE_SETPOINT = 16'h0020;
   localparam logic [15:0] CMD_CURRENT_SETPOINT = 16'h0030;
   localparam logic [15:0] CMD_CHG_FLAGS = 16'h00b8;
   localparam logic [15:0] CMD_SCALE = 16'h00c0;
   localparam logic [15:0] CMD_HEALTH = 16'h00c1;
   localparam logic [15:0] CMD_SETUP = 16'h00c2;
   localparam logic [28:0] ID_REQ_BASE = 29'h000c0100;
   localparam logic [28:0] ID_RSP_BASE = 29'h000c0000;
   localparam logic [3:0] DLC_READ = 4'h2;
   localparam logic [3:0] DLC_WRITE = 4'h4;
   localparam logic [3:0] DLC_RSP_BYTE = 4'h3;
   localparam logic [3:0] DLC_RSP_WORD = 4'h4;
   localparam logic [3:0] DLC_RSP_SCALE = 4'h8;
   localparam logic [3:0] SCALE_NONE = 4'h0;
   localparam logic [3:0] SCALE_0P001 = 4'h4;
   localparam logic [3:0] SCALE_0P01 = 4'h5;
   localparam logic [3:0] SCALE_0P1 = 4'h6;
   localparam logic [3:0] SCALE_1 = 4'h7;
   localparam logic [3:0] SCALE_10 = 4'h8;
   localparam logic [3:0] SCALE_100 = 4'h9;
   localparam int SETUP_BUS_CTRL = 0;
   localparam int SETUP_INIT_LO = 1;
   localparam int SETUP_POLICY_LO = 8;
   localparam int SETUP_SAVE_OFF = 10;
   localparam logic [1:0] INIT_OFF = 2'b00;
   localparam logic [1:0] INIT_ON = 2'b01;
   localparam logic [1:0] INIT_PREV = 2'b10;
   localparam logic [1:0] INIT_RSVD = 2'b11;
   localparam logic [1:0] POLICY_NOW = 2'b00;
   localparam logic [1:0] POLICY_1MIN = 2'b01;
   localparam logic [1:0] POLICY_10MIN = 2'b10;
   localparam logic [1:0] POLICY_RSVD = 2'b11;
   localparam logic [15:0] SETUP_RESET = 16'h0000;
   localparam logic [15:0] SETUP_MASK = 16'h0707;
   localparam int CLK_HZ = 10_000_000;
   localparam int DELAY_1MIN_S = 60;
   localparam int DELAY_10MIN_S = 600;
   localparam longint DELAY_1MIN_CYC = longint'(DELAY_1MIN_S) * CLK_HZ;
   localparam longint DELAY_10MIN_CYC = longint'(DELAY_10MIN_S) * CLK_HZ;
endpackage

// ==== rtl/psr_regs.sv ====
/*
 Status, scaling and system configuration register set of a
 programmable supply and charger, reached through CAN command frames.
 Assumes status inputs are asynchronous pins and the frame port is
 driven by a CAN controller on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Charge stage flags in low byte bits 0..3: full, CC, CV, float.
// [R2] High byte bit 2 flags temp sense short, bit 3 flags no battery.
// [R3] High byte bits 5,6,7 flag CC, CV, float stage timeouts; here bit 7 (float) has no pin and reads zero.
// [R4] Bits for unsupported functions always read zero.
// [R5] Scaling nibble: 0 unsupported, 4..9 mean 0.001 up to 100.
// [R6] Scaling byte 0: voltage factor low nibble, current factor high nibble.
// [R7] Scaling byte 1: input voltage low nibble, fan speed high nibble.
// [R8] Scaling byte 2: temperature low nibble, stage timeout high nibble.
// [R9] Scaling byte 3: input current low nibble; rest and bytes 4,5 reserved.
// [R10] Health bit 1 is one when secondary output voltage is normal.
// [R11] Health bit 4 is one while dummy load is on.
// [R12] Health bit 5 is zero during initialization, one after.
// [R13] Health bit 6 flags a failed nonvolatile memory access.
// [R14] Setup bit 0 selects bus setpoints over analog trim inputs.
// [R15] Setup bits 1..2 choose power-up on/off: off, on, previous; here the preset uses the reset value 00 and always powers up off.
// [R16] Commit policy: immediate, after 1 minute or 10 minutes quiet.
// [R17] Setup high bit 2 set stops all saving to nonvolatile memory.
// [R18] Write frame: length 4, command then parameter, low byte first.
// [R19] Read frame: length 2; answer echoes command then data.
// [R20] On/off readback returns single byte 0x01 while output runs.
// [R21] Values are raw integers scaled by their factor.
// [R22] Reserved preset or policy codes are ignored on write.
module psr_regs
   import psr_pkg::*;
#(
   parameter longint DELAY_1MIN = DELAY_1MIN_CYC,
   parameter longint DELAY_10MIN = DELAY_10MIN_CYC
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [28:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   input wire logic [7:0] unit_addr,
   input wire logic [7:0] stage_pins,
   input wire logic [3:0] health_pins,
   input wire logic stored_on,
   input wire logic nvm_done,
   input wire logic [15:0] voltage_trim_input,
   input wire logic [15:0] current_trim_input,
   input wire logic trim_on,
   output logic tx_valid,
   output logic [28:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   output logic [15:0] voltage_target,
   output logic [15:0] current_target,
   output logic output_on,
   output logic nvm_write
);
   localparam logic [3:0] F_VOUT = SCALE_0P01;
   localparam logic [3:0] F_IOUT = SCALE_0P01;
   localparam logic [3:0] F_VIN = SCALE_0P1;
   localparam logic [3:0] F_FAN = SCALE_NONE;
   localparam logic [3:0] F_TEMP = SCALE_0P1;
   localparam logic [3:0] F_TMO = SCALE_1;
   localparam logic [3:0] F_IIN = SCALE_NONE;

   psr_frame_if fr ();
   psr_frame_dec u_dec (
      .mclk(mclk),
      .reset_n(reset_n),
      .rx_valid(rx_valid),
      .rx_id(rx_id),
      .rx_dlc(rx_dlc),
      .rx_data(rx_data),
      .unit_addr(unit_addr),
      .fr(fr)
   );

   // Two-flop synchronisers for status pins
   logic [13:0] sync1, sync2;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 14'h0000;
         sync2 <= 14'h0000;
      end else begin
         sync1 <= {stored_on, health_pins, stage_pins, nvm_done};
         sync2 <= sync1;
      end
   end
   logic stored_on_s, nvm_done_s;
   logic [3:0] health_s;
   logic [7:0] stage_s;
   assign {stored_on_s, health_s, stage_s, nvm_done_s} = sync2;

   logic [15:0] charger_stage_flags;
   logic [15:0] unit_health_flags;
   logic [47:0] value_scale_table;
   logic [15:0] unit_setup;
   logic [15:0] voltage_setpoint;
   logic [15:0] current_setpoint;
   logic bus_on;
   logic init_done;
   // Stage bits 0..3 full/CC/CV/float, 4 tsense short, 5 no battery, 6..7 CC/CV tmo
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         charger_stage_flags <= 16'h0000;
      else
         charger_stage_flags <= {1'b0, stage_s[7:6], 1'b0, stage_s[5:4], 2'b00, 4'h0, stage_s[3:0]}; // [R1] [R2] [R3] [R4]
   end
   // Float timeout has no pin here, so word bit 15 stays zero
   logic [15:0] chg_word;
   assign chg_word = charger_stage_flags; // [R3] [R4]

   assign value_scale_table = {16'h0000, 4'h0, F_IIN, F_TMO, F_TEMP, F_FAN, F_VIN, F_IOUT, F_VOUT}; // [R5] [R6] [R7] [R8] [R9] [R21]

   // Health: bit1 output good, bit4 dummy load, bit5 init done, bit6 nvm error
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         unit_health_flags <= 16'h0000;
      else
         unit_health_flags <= {9'h000, health_s[3], init_done, health_s[2], 2'b00, health_s[0], 1'b0}; // [R10] [R11] [R12] [R13] [R4]
   end

   // Init completes once the power-up preset has been applied
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         init_done <= 1'b0;
      else
         init_done <= 1'b1; // [R12]
   end

   logic setpoint_wr;
   assign setpoint_wr = fr.req && fr.wr &&
      (fr.cmd == CMD_OPERATION || fr.cmd == CMD_VOLTAGE_SETPOINT || fr.cmd == CMD_CURRENT_SETPOINT || fr.cmd == CMD_SETUP);

   // Setup register with reserved codes refused field by field
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         unit_setup <= SETUP_RESET;
      end else if (fr.req && fr.wr && fr.cmd == CMD_SETUP) begin
         unit_setup[SETUP_BUS_CTRL] <= fr.data[SETUP_BUS_CTRL]; // [R14]
         unit_setup[SETUP_SAVE_OFF] <= fr.data[SETUP_SAVE_OFF]; // [R17]
         if (fr.data[SETUP_INIT_LO +: 2] != INIT_RSVD)
            unit_setup[SETUP_INIT_LO +: 2] <= fr.data[SETUP_INIT_LO +: 2]; // [R15] [R22]
         if (fr.data[SETUP_POLICY_LO +: 2] != POLICY_RSVD)
            unit_setup[SETUP_POLICY_LO +: 2] <= fr.data[SETUP_POLICY_LO +: 2]; // [R16] [R22]
      end
   end

   // Bus setpoints and on/off, preset at power-up
   logic preset_done;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         voltage_setpoint <= 16'h0000;
         current_setpoint <= 16'h0000;
         bus_on <= 1'b0;
         preset_done <= 1'b0;
      end else begin
         preset_done <= 1'b1;
         if (!preset_done) begin
            unique case (unit_setup[SETUP_INIT_LO +: 2])
               INIT_OFF: bus_on <= 1'b0; // [R15]
               INIT_ON: bus_on <= 1'b1; // [R15]
               INIT_PREV: bus_on <= stored_on_s; // [R15]
               INIT_RSVD: bus_on <= 1'b0;
            endcase
         end else if (fr.req && fr.wr) begin
            if (fr.cmd == CMD_OPERATION)
               bus_on <= fr.data[0];
            if (fr.cmd == CMD_VOLTAGE_SETPOINT)
               voltage_setpoint <= fr.data; // [R21]
            if (fr.cmd == CMD_CURRENT_SETPOINT)
               current_setpoint <= fr.data; // [R21]
         end
      end
   end

   // Output source selection
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         voltage_target <= 16'h0000;
         current_target <= 16'h0000;
         output_on <= 1'b0;
      end else if (unit_setup[SETUP_BUS_CTRL]) begin
         voltage_target <= voltage_setpoint; // [R14]
         current_target <= current_setpoint;
         output_on <= bus_on;
      end else begin
         voltage_target <= voltage_trim_input; // [R14]
         current_target <= current_trim_input;
         output_on <= trim_on;
      end
   end

   // Commit timer: restarts on each change, fires after the quiet time
   logic [33:0] quiet_cnt;
   logic pending;
   logic [33:0] quiet_limit;
   always_comb begin
      unique case (unit_setup[SETUP_POLICY_LO +: 2])
         POLICY_1MIN: quiet_limit = 34'(DELAY_1MIN - 1);
         POLICY_10MIN: quiet_limit = 34'(DELAY_10MIN - 1);
         default: quiet_limit = 34'h0;
      endcase
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pending <= 1'b0;
         quiet_cnt <= 34'h0;
         nvm_write <= 1'b0;
      end else begin
         nvm_write <= 1'b0;
         if (setpoint_wr) begin
            pending <= !unit_setup[SETUP_SAVE_OFF]; // [R17]
            quiet_cnt <= 34'h0;
         end else if (pending && unit_setup[SETUP_SAVE_OFF]) begin
            pending <= 1'b0; // [R17]
         end else if (pending) begin
            if (quiet_cnt >= quiet_limit) begin
               pending <= 1'b0;
               nvm_write <= 1'b1; // [R16]
            end else begin
               quiet_cnt <= quiet_cnt + 34'h1;
            end
         end
      end
   end

   // Read answers echo the command then the data
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_valid <= 1'b0;
         tx_id <= 29'h0;
         tx_dlc <= 4'h0;
         tx_data <= 64'h0;
      end else begin
         tx_valid <= fr.req && !fr.wr; // [R19]
         if (fr.req && !fr.wr) begin
            tx_id <= ID_RSP_BASE | {21'h0, unit_addr}; // [R19]
            tx_data <= 64'h0;
            tx_data[15:0] <= fr.cmd; // [R19]
            tx_dlc <= DLC_RSP_WORD;
            if (fr.cmd == CMD_OPERATION) begin
               tx_dlc <= DLC_RSP_BYTE;
               tx_data[23:16] <= {7'h00, output_on}; // [R20]
            end else if (fr.cmd == CMD_CHG_FLAGS)
               tx_data[31:16] <= chg_word; // [R1]
            else if (fr.cmd == CMD_HEALTH)
               tx_data[31:16] <= unit_health_flags;
            else if (fr.cmd == CMD_SETUP)
               tx_data[31:16] <= unit_setup & SETUP_MASK; // [R4]
            else if (fr.cmd == CMD_SCALE) begin
               tx_dlc <= DLC_RSP_SCALE;
               tx_data[63:16] <= value_scale_table; // [R5]
            end else if (fr.cmd == CMD_VOLTAGE_SETPOINT)
               tx_data[31:16] <= voltage_setpoint;
            else if (fr.cmd == CMD_CURRENT_SETPOINT)
               tx_data[31:16] <= current_setpoint;
         end
      end
   end

   rsvd_init_kept_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fr.req && fr.wr && fr.cmd == CMD_SETUP && fr.data[2:1] == INIT_RSVD
      |=> unit_setup[2:1] == $past(unit_setup[2:1])) else $error("reserved preset stored"); // [R22]
   rsvd_policy_kept_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fr.req && fr.wr && fr.cmd == CMD_SETUP && fr.data[9:8] == POLICY_RSVD
      |=> unit_setup[9:8] == $past(unit_setup[9:8])) else $error("reserved policy stored"); // [R22]
   read_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fr.req && !fr.wr |=> tx_valid && tx_data[15:0] == $past(fr.cmd))
      else $error("read not echoed"); // [R19]
   no_save_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      unit_setup[SETUP_SAVE_OFF] && $past(unit_setup[SETUP_SAVE_OFF]) && !$past(pending) |-> !nvm_write)
      else $error("save while disabled"); // [R17]
   immediate_commit_a: assert property (@(posedge mclk) disable iff (!reset_n)
      setpoint_wr && unit_setup[10:8] == 3'b000 && fr.cmd != CMD_SETUP ##1 !setpoint_wr |=> nvm_write)
      else $error("immediate commit late"); // [R16]
   source_sel_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !unit_setup[0] && $stable(unit_setup[0]) |=> voltage_target == $past(voltage_trim_input))
      else $error("trim not followed"); // [R14]
   on_readback_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tx_valid && tx_data[15:0] == 16'h0000 |-> tx_dlc == DLC_RSP_BYTE && tx_data[63:24] == 40'h0)
      else $error("on/off answer shape"); // [R20]
   scale_fixed_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tx_valid && tx_dlc == DLC_RSP_SCALE |-> tx_data[63:44] == 20'h0 && tx_data[19:16] == F_VOUT)
      else $error("scale table wrong"); // [R9]
   init_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ##3 1 |-> unit_health_flags[5]) else $error("init never done"); // [R12]

   read_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) tx_valid);
   write_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) setpoint_wr);
   commit_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) nvm_write);
   bus_ctrl_c: cover property (@(posedge mclk) disable iff (!reset_n) unit_setup[0] && output_on);
endmodule
`default_nettype wire

// ==== tb/psr_can_master.sv ====
/*
 Bus master model: sends request frames to the register set.
 Assumes frames are taken on the rising clock as one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_can_master
   import psr_pkg::*;
(
   input wire logic mclk,
   output logic rx_valid,
   output logic [28:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_id = 29'h0;
      rx_dlc = 4'h0;
      rx_data = 64'h0;
   end
   // One-cycle frame; idle lines then show inverted values
   task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] data);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_dlc <= dlc;
      rx_data <= data;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_id <= ~id;
      rx_dlc <= ~dlc;
      rx_data <= ~data;
   endtask
   task automatic rd(input logic [7:0] addr, input logic [15:0] cmd);
      send(ID_REQ_BASE | {21'h0, addr}, DLC_READ, {48'h5a5a_5a5a_5a5a, cmd});
   endtask
   task automatic wr(input logic [7:0] addr, input logic [15:0] cmd, input logic [15:0] prm);
      send(ID_REQ_BASE | {21'h0, addr}, DLC_WRITE, {32'ha5a5_a5a5, prm, cmd});
   endtask
endmodule
`default_nettype wire

// ==== tb/psr_regs_tb.sv ====
/*
 Self-checking bench for the register set.
 Assumes the master model drives frames and shortened commit delays.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_regs_tb
   import psr_pkg::*;
;
   localparam logic [7:0] ADDR = 8'h01;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic rx_valid, tx_valid, output_on, nvm_write, stored_on, nvm_done, trim_on;
   logic [28:0] rx_id, tx_id;
   logic [3:0] rx_dlc, tx_dlc, health_pins;
   logic [63:0] rx_data, tx_data;
   logic [7:0] stage_pins;
   logic [15:0] voltage_trim_input, current_trim_input, voltage_target, current_target;
   int err_count = 0;
   int check_count = 0;
   int txv_cnt = 0;
   int nvm_cnt = 0;

   always #50 mclk = ~mclk;

   psr_can_master u_master (.mclk(mclk), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data));

   psr_regs #(.DELAY_1MIN(20), .DELAY_10MIN(50)) u_dut (
      .mclk(mclk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
      .rx_data(rx_data), .unit_addr(ADDR), .stage_pins(stage_pins), .health_pins(health_pins),
      .stored_on(stored_on), .nvm_done(nvm_done), .voltage_trim_input(voltage_trim_input),
      .current_trim_input(current_trim_input), .trim_on(trim_on), .tx_valid(tx_valid),
      .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .voltage_target(voltage_target),
      .current_target(current_target), .output_on(output_on), .nvm_write(nvm_write));

   // Pulse counters, sampled on the rising edge
   always @(posedge mclk) begin
      if (tx_valid === 1'b1) txv_cnt++;
      if (nvm_write === 1'b1) nvm_cnt++;
   end

   initial begin
      stage_pins = 8'h00;
      health_pins = 4'h0;
      stored_on = 1'b0;
      nvm_done = 1'b0;
      voltage_trim_input = 16'h1357;
      current_trim_input = 16'h2468;
      trim_on = 1'b0;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      if (err_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Read one command and compare the answer frame
   task automatic rd_chk(input logic [15:0] cmd, input logic [3:0] dlc, input logic [63:0] exp);
      logic [63:0] msk;
      int n;
      msk = (64'h1 << (dlc * 8)) - 64'h1;
      n = 0;
      u_master.rd(ADDR, cmd);
      while (tx_valid !== 1'b1 && n < 8) begin
         @(negedge mclk);
         n++;
      end
      chk({63'h0, tx_valid}, 64'h1);
      chk({35'h0, tx_id}, {35'h0, ID_RSP_BASE | {21'h0, ADDR}});
      chk({60'h0, tx_dlc}, {60'h0, dlc});
      chk(tx_data & msk, exp);
      @(negedge mclk);
      chk({63'h0, tx_valid}, 64'h0);
   endtask

   // Count answers and commits over a span of cycles
   task automatic quiet(input int n, input int exp_tx, input int exp_nvm);
      int t0;
      int c0;
      t0 = txv_cnt;
      c0 = nvm_cnt;
      repeat (n) @(negedge mclk);
      chk(64'(txv_cnt - t0), 64'(exp_tx));
      chk(64'(nvm_cnt - c0), 64'(exp_nvm));
   endtask

   task automatic t_setup();
      rd_chk(CMD_SETUP, DLC_RSP_WORD, {32'h0, SETUP_RESET, CMD_SETUP});
      u_master.wr(ADDR, CMD_SETUP, 16'h0105);
      rd_chk(CMD_SETUP, DLC_RSP_WORD, {32'h0, 16'h0105, CMD_SETUP});
      u_master.wr(ADDR, CMD_SETUP, 16'h0307);
      rd_chk(CMD_SETUP, DLC_RSP_WORD, {32'h0, 16'h0105, CMD_SETUP});
      u_master.wr(ADDR, CMD_SETUP, 16'hf8f1);
      rd_chk(CMD_SETUP, DLC_RSP_WORD, {32'h0, 16'h0001, CMD_SETUP});
   endtask

   task automatic t_chg();
      logic [7:0] p;
      for (int i = 0; i < 2; i++) begin
         p = (i == 0) ? 8'ha5 : 8'h5a;
         @(posedge mclk);
         stage_pins <= p;
         repeat (4) @(posedge mclk);
         rd_chk(CMD_CHG_FLAGS, DLC_RSP_WORD, {32'h0, 1'b0, p[7:6], 1'b0, p[5:4], 6'h0, p[3:0], CMD_CHG_FLAGS});
      end
   endtask

   task automatic t_scale();
      rd_chk(CMD_SCALE, DLC_RSP_SCALE, {16'h0, 8'h00, 8'h76, 8'h06, 8'h55, CMD_SCALE});
   endtask

   task automatic t_health();
      logic [3:0] h;
      for (int i = 0; i < 2; i++) begin
         h = (i == 0) ? 4'hd : 4'h2;
         @(posedge mclk);
         health_pins <= h;
         repeat (4) @(posedge mclk);
         rd_chk(CMD_HEALTH, DLC_RSP_WORD, {32'h0, 9'h0, h[3], 1'b1, h[2], 2'b0, h[0], 1'b0, CMD_HEALTH});
      end
   endtask

   task automatic t_bus();
      u_master.wr(ADDR, CMD_SETUP, 16'h0001);
      u_master.wr(ADDR, CMD_VOLTAGE_SETPOINT, 16'h0bb8);
      u_master.wr(ADDR, CMD_CURRENT_SETPOINT, 16'h1234);
      u_master.wr(ADDR, CMD_OPERATION, 16'h0001);
      repeat (4) @(negedge mclk);
      chk({48'h0, voltage_target}, 64'h0bb8);
      chk({48'h0, current_target}, 64'h1234);
      chk({63'h0, output_on}, 64'h1);
      rd_chk(CMD_OPERATION, DLC_RSP_BYTE, 64'h01_0000);
      u_master.wr(ADDR, CMD_SETUP, 16'h0000);
      repeat (6) @(negedge mclk);
      chk({48'h0, voltage_target}, 64'h1357);
      chk({48'h0, current_target}, 64'h2468);
      chk({63'h0, output_on}, 64'h0);
   endtask

   // Set a policy, let its own commit pass, then change a value
   task automatic policy(input logic [15:0] v);
      u_master.wr(ADDR, CMD_SETUP, v);
      repeat (70) @(negedge mclk);
      u_master.wr(ADDR, CMD_VOLTAGE_SETPOINT, 16'h0c00);
   endtask

   task automatic t_commit();
      policy(16'h0001);
      quiet(6, 0, 1);
      policy(16'h0101);
      quiet(10, 0, 0);
      quiet(30, 0, 1);
      policy(16'h0201);
      quiet(40, 0, 0);
      quiet(30, 0, 1);
      policy(16'h0401);
      quiet(80, 0, 0);
   endtask

   task automatic t_refuse();
      u_master.rd(8'h02, CMD_SETUP);
      quiet(8, 0, 0);
      u_master.send(ID_REQ_BASE | {21'h0, ADDR}, 4'h3, {48'h0, CMD_SETUP});
      quiet(8, 0, 0);
   endtask

   initial begin
      #2_000_000;
      err_count++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_setup();
      t_chg();
      t_scale();
      t_health();
      t_bus();
      t_commit();
      t_refuse();
      summarize();
   end
endmodule
`default_nettype wire
